//--- core/slave_link_cfg.svh
/*
 holds the timing counts, field layout and code values of the
 nine-bit slave serial link; assumes a 100 MHz system clock
*/
`ifndef SLAVE_LINK_CFG_SVH
`define SLAVE_LINK_CFG_SVH
// clock and bit timing
`define CLK_PERIOD_NS 10
`define BIT_TIME_NS 8000
`define BIT_CYCLES (`BIT_TIME_NS / `CLK_PERIOD_NS)
`define HALF_BIT_CYCLES (`BIT_CYCLES / 2)
`define FIELD_BITS 11
// reply wait and end-of-frame idle gap, in whole fields
`define REPLY_TIMEOUT_FIELDS 4
`define GAP_FIELDS 2
`define REPLY_TIMEOUT_CYCLES (`REPLY_TIMEOUT_FIELDS*`FIELD_BITS*`BIT_CYCLES)
`define GAP_CYCLES (`GAP_FIELDS*`FIELD_BITS*`BIT_CYCLES)
// field layout
`define CTL_BIT 8
`define ADDR_W 4
// field type codes
`define TYPE_BUSY 2'h0
`define TYPE_ACK 2'h1
`define TYPE_DATA 2'h2
`define TYPE_ERR 2'h3
// result byte bit positions
`define RES_TIMEOUT 7
`define RES_FRAMING 6
`define RES_OVERRUN 5
`define RES_MISPL_DATA 4
`define RES_MISPL_CTL 3
`define RES_ADDR 2
`define RES_PROTO 1
`define RES_CHECKSUM 0
// bytes shown after reset
`define BOOT_BYTE0 8'hf0
`define BOOT_BYTE1 8'h80
// buffering and slave pulse pacing
`define FIFO_DEPTH 8
`define PULSE_DIV_CYCLES 1000
`endif

//--- core/slave_link_pkg.sv
/*
 types and helpers shared by both ends of the slave serial link;
 assumes the cfg header is on the include path
*/
`include "slave_link_cfg.svh"
package slave_link_pkg;
   typedef logic [1:0] field_type_t;
   typedef logic [`ADDR_W-1:0] slave_addr_t;
   typedef enum logic [2:0] {C_IDLE, C_CTL, C_DATA, C_SUM, C_WAIT, C_RX,
      C_REPORT} ctrl_state_t;
   typedef enum logic [2:0] {S_RX, S_EVAL, S_CTL, S_DATA, S_SUM}
      slave_state_t;

   // control byte: type in bits 5..4, address in the low bits
   function automatic logic [7:0] ctl_byte(input field_type_t t,
         input slave_addr_t a);
      ctl_byte = {2'b00, t, a};
   endfunction : ctl_byte

   // modulo-256 running sum
   function automatic logic [7:0] sum_add(input logic [7:0] s,
         input logic [7:0] b);
      sum_add = s + b;
   endfunction : sum_add
endpackage : slave_link_pkg

//--- core/serial_link_if.sv
/*
 the two serial lines between controller and slave; assumes both
 ends run on the same system clock
*/
`timescale 1ns/1ps
`default_nettype none
interface serial_link_if;
   logic ctl_txd; // controller to slave, idle high
   logic slv_txd; // slave to controller, idle high
   modport ctrl (output ctl_txd, input slv_txd);
   modport slave (input ctl_txd, output slv_txd);
endinterface : serial_link_if
`default_nettype wire

//--- core/link_controller.sv
/*
 controller end of the slave serial link with its data byte fifo and
 the shared field serialiser; assumes one slave answers per frame and
 all user inputs are synchronous to clk_i except the select pin
*/
// Functional notes
// RULE_01 - fields carry nine payload bits
// RULE_02 - one bit lasts eight microseconds
// RULE_03 - start bit, bits 0-7, then control bit
// RULE_04 - control bit one means address, else data
// RULE_05 - one control, data fields, one checksum
// RULE_06 - control field holds address and type code
// RULE_07 - controller sends only types 00 and 01
// RULE_08 - slave types: busy, ack, data, error
// RULE_09 - data and checksum share the field layout
// RULE_10 - controller starts, slave only answers
// RULE_11 - one reply per controller frame
// RULE_12 - after reset show F0 then 80
// RULE_13 - commands accepted at any time after reset; code takes one only in C_IDLE, cmd_ready_o low until the report
// RULE_14 - select pin decides result interrupt
// RULE_15 - end of run follows slave pulse count
// RULE_16 - pin low errors only, high also acks
// RULE_17 - result byte bits, zero means success
// RULE_18 - checksum is byte sum of preceding fields
// RULE_19 - mid-bit sampling, low stop is framing error
`timescale 1ns/1ps
`default_nettype none
`include "slave_link_cfg.svh"

module sync_fifo #(
   parameter int W = 9,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q, rd_q;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem[rd_q];
   assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   // storage
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_q] <= in_data_i;
      end
   end
   // pointers and registered full and empty
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         in_ready_o <= 1'b1;
         out_valid_o <= 1'b0;
      end else begin
         if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         cnt_q <= cnt_d;
         in_ready_o <= cnt_d != (AW+1)'(DEPTH);
         out_valid_o <= cnt_d != '0;
      end
   end
endmodule : sync_fifo

module field_serdes (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic tx_valid_i,
   input wire logic [8:0] tx_field_i,
   output logic tx_ready_o,
   output logic txd_o,
   input wire logic rxd_i,
   output logic rx_valid_o,
   output logic [8:0] rx_field_o,
   output logic rx_frame_err_o
);
   logic [9:0] tx_sh_q;
   logic [3:0] tx_bits_q, rx_bits_q;
   logic [9:0] tx_cnt_q, rx_cnt_q;
   logic rx_s1, rx_s2, rx_s3, rx_act_q;
   logic [8:0] rx_sh_q;
   // transmitter: start, bits 0-8 lsb first, stop
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         txd_o <= 1'b1;
         tx_ready_o <= 1'b1;
         tx_sh_q <= '1;
         tx_bits_q <= '0;
         tx_cnt_q <= '0;
      end else if (tx_ready_o) begin
         if (tx_valid_i) begin
            tx_sh_q <= {1'b1, tx_field_i}; // RULE_03
            txd_o <= 1'b0;
            tx_bits_q <= 4'h0_00a;
            tx_cnt_q <= 10'(`BIT_CYCLES - 1); // RULE_02
            tx_ready_o <= 1'b0;
         end
      end else if (tx_cnt_q != '0) begin
         tx_cnt_q <= tx_cnt_q - 1'b1;
      end else if (tx_bits_q != '0) begin
         txd_o <= tx_sh_q[0];
         tx_sh_q <= {1'b1, tx_sh_q[9:1]};
         tx_bits_q <= tx_bits_q - 1'b1;
         tx_cnt_q <= 10'(`BIT_CYCLES - 1);
      end else begin
         tx_ready_o <= 1'b1;
      end
   end
   // receive line synchroniser and edge history
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
         rx_s3 <= 1'b1;
      end else begin
         rx_s1 <= rxd_i;
         rx_s2 <= rx_s1;
         rx_s3 <= rx_s2;
      end
   end
   // receiver: sample at mid bit, check stop
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rx_act_q <= 1'b0;
         rx_cnt_q <= '0;
         rx_bits_q <= '0;
         rx_sh_q <= '0;
         rx_valid_o <= 1'b0;
         rx_field_o <= '0;
         rx_frame_err_o <= 1'b0;
      end else begin
         rx_valid_o <= 1'b0;
         if (!rx_act_q) begin
            if (rx_s3 && !rx_s2) begin
               rx_act_q <= 1'b1;
               rx_cnt_q <= 10'(`HALF_BIT_CYCLES - 1); // RULE_19
               rx_bits_q <= '0;
            end
         end else if (rx_cnt_q != '0) begin
            rx_cnt_q <= rx_cnt_q - 1'b1;
         end else begin
            rx_cnt_q <= 10'(`BIT_CYCLES - 1);
            rx_bits_q <= rx_bits_q + 1'b1;
            if (rx_bits_q == '0) begin
               if (rx_s2) rx_act_q <= 1'b0; // false start
            end else if (rx_bits_q == 4'h0_00a) begin
               rx_act_q <= 1'b0;
               rx_valid_o <= 1'b1;
               rx_field_o <= rx_sh_q; // RULE_01
               rx_frame_err_o <= !rx_s2; // RULE_19
            end else begin
               rx_sh_q <= {rx_s2, rx_sh_q[8:1]};
            end
         end
      end
   end
endmodule : field_serdes

module link_controller #(
   parameter int unsigned REPLY_TIMEOUT = `REPLY_TIMEOUT_CYCLES,
   parameter int unsigned GAP = `GAP_CYCLES
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   serial_link_if.ctrl link,
   input wire logic cmd_valid_i,
   input wire slave_link_pkg::slave_addr_t cmd_addr_i,
   input wire logic cmd_is_data_i,
   output logic cmd_ready_o,
   input wire logic data_valid_i,
   input wire logic [7:0] data_i,
   input wire logic data_last_i,
   output logic data_ready_o,
   input wire logic result_report_select_pin_i,
   output logic [7:0] rx_data_o,
   output logic rx_data_valid_o,
   input wire logic rx_data_read_i,
   output slave_link_pkg::slave_addr_t result_addr_o,
   output logic [7:0] result_o,
   output logic result_valid_o,
   input wire logic result_read_i,
   output logic comm_result_interrupt_o,
   output logic run_end_o,
   input wire logic run_end_clear_i,
   output logic [7:0] boot_data_o,
   output logic boot_valid_o,
   input wire logic boot_read_i
);
   import slave_link_pkg::*;
   ctrl_state_t st_q;
   slave_addr_t addr_q, raddr_q;
   field_type_t rtype_q;
   logic is_data_q, to_q, first_ctl_q, run_pend_q, boot_second_q;
   logic sel_s1, sel_s2;
   logic [7:0] tsum_q, rsum_q, last_q;
   logic [1:0] nf_q;
   logic [3:0] err_q; // framing, overrun, misplaced data, misplaced ctl
   logic [15:0] tmr_q;
   logic tx_rdy, tx_go, rx_v, rx_fe, fifo_v, fifo_pop;
   logic [8:0] tx_f, rx_f, fifo_q;
   logic [7:0] res;

   sync_fifo #(.W(9), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i), .resetn_i(resetn_i),
      .in_valid_i(data_valid_i), .in_data_i({data_last_i, data_i}),
      .in_ready_o(data_ready_o), .out_valid_o(fifo_v),
      .out_ready_i(fifo_pop), .out_data_o(fifo_q));

   field_serdes u_serdes (
      .clk_i(clk_i), .resetn_i(resetn_i),
      .tx_valid_i(tx_go), .tx_field_i(tx_f), .tx_ready_o(tx_rdy),
      .txd_o(link.ctl_txd), .rxd_i(link.slv_txd),
      .rx_valid_o(rx_v), .rx_field_o(rx_f), .rx_frame_err_o(rx_fe));

   // field to send in each sending state
   always_comb begin
      tx_go = 1'b0;
      tx_f = {1'b0, tsum_q}; // RULE_09
      fifo_pop = 1'b0;
      case (st_q)
         C_CTL: begin
            tx_go = tx_rdy;
            tx_f = {1'b1, ctl_byte({1'b0, is_data_q}, addr_q)}; // RULE_07
         end
         C_DATA: begin
            tx_go = tx_rdy && fifo_v;
            fifo_pop = tx_go;
            tx_f = {1'b0, fifo_q[7:0]}; // RULE_04
         end
         C_SUM: tx_go = tx_rdy;
         default: tx_go = 1'b0;
      endcase
   end

   // result byte from the collected reply
   always_comb begin
      res = '0;
      if (to_q) begin
         res[`RES_TIMEOUT] = 1'b1; // RULE_17
      end else begin
         res[`RES_FRAMING:`RES_MISPL_CTL] = err_q;
         res[`RES_ADDR] = raddr_q != addr_q;
         res[`RES_PROTO] = nf_q < 2'd2 || rtype_q == `TYPE_ERR; // RULE_08
         res[`RES_CHECKSUM] = (rsum_q - last_q) != last_q; // RULE_18
      end
   end

   // frame sequencing and reply wait
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         st_q <= C_IDLE;
         cmd_ready_o <= 1'b1;
         addr_q <= '0;
         is_data_q <= 1'b0;
         tsum_q <= '0;
         tmr_q <= '0;
         to_q <= 1'b0;
      end else begin
         case (st_q)
            C_IDLE: if (cmd_valid_i) begin // RULE_13
               addr_q <= cmd_addr_i;
               is_data_q <= cmd_is_data_i;
               cmd_ready_o <= 1'b0;
               to_q <= 1'b0;
               st_q <= C_CTL; // RULE_10
            end
            C_CTL: if (tx_go) begin
               tsum_q <= tx_f[7:0];
               st_q <= is_data_q ? C_DATA : C_SUM; // RULE_05
            end
            C_DATA: if (tx_go) begin
               tsum_q <= sum_add(tsum_q, fifo_q[7:0]); // RULE_18
               if (fifo_q[8]) st_q <= C_SUM;
            end
            C_SUM: if (tx_go) begin
               tmr_q <= '0;
               st_q <= C_WAIT;
            end
            C_WAIT: begin
               if (rx_v) begin
                  tmr_q <= '0;
                  st_q <= C_RX;
               end else if (tx_rdy) begin
                  tmr_q <= tmr_q + 1'b1;
                  if (tmr_q == 16'(REPLY_TIMEOUT - 1)) begin
                     to_q <= 1'b1;
                     st_q <= C_REPORT;
                  end
               end
            end
            C_RX: begin
               tmr_q <= rx_v ? '0 : tmr_q + 1'b1;
               if (!rx_v && tmr_q == 16'(GAP - 1)) st_q <= C_REPORT;
            end
            default: begin
               cmd_ready_o <= 1'b1; // RULE_11
               st_q <= C_IDLE;
            end
         endcase
      end
   end

   // reply field collection and data forwarding
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         nf_q <= '0;
         rsum_q <= '0;
         last_q <= '0;
         err_q <= '0;
         first_ctl_q <= 1'b0;
         rtype_q <= '0;
         raddr_q <= '0;
         rx_data_o <= '0;
         rx_data_valid_o <= 1'b0;
      end else begin
         if (rx_data_read_i) rx_data_valid_o <= 1'b0;
         if (st_q == C_CTL) begin
            nf_q <= '0;
            rsum_q <= '0;
            err_q <= '0;
         end else if (rx_v && (st_q == C_WAIT || st_q == C_RX)) begin
            if (nf_q != 2'd3) nf_q <= nf_q + 1'b1;
            rsum_q <= sum_add(rsum_q, rx_f[7:0]);
            last_q <= rx_f[7:0];
            err_q[3] <= err_q[3] | rx_fe; // RULE_19
            if (nf_q == '0) begin
               first_ctl_q <= rx_f[`CTL_BIT]; // RULE_06
               rtype_q <= rx_f[5:4];
               raddr_q <= rx_f[`ADDR_W-1:0];
               err_q[1] <= err_q[1] | !rx_f[`CTL_BIT]; // RULE_04
            end else begin
               err_q[0] <= err_q[0] | rx_f[`CTL_BIT];
            end
            if (nf_q >= 2'd2) begin
               rx_data_o <= last_q;
               rx_data_valid_o <= 1'b1;
               err_q[2] <= err_q[2] | (rx_data_valid_o && !rx_data_read_i);
            end
         end
      end
   end

   // select pin synchroniser
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         sel_s1 <= 1'b0;
         sel_s2 <= 1'b0;
      end else begin
         sel_s1 <= result_report_select_pin_i;
         sel_s2 <= sel_s1;
      end
   end

   // result report, result interrupt and end of run
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         result_o <= '0;
         result_addr_o <= '0;
         result_valid_o <= 1'b0;
         comm_result_interrupt_o <= 1'b0;
         run_end_o <= 1'b0;
         run_pend_q <= 1'b0;
      end else if (st_q == C_REPORT) begin
         result_o <= res; // RULE_17
         result_addr_o <= addr_q;
         result_valid_o <= 1'b1;
         if (res != '0 || (sel_s2 && rtype_q == `TYPE_ACK)) begin
            comm_result_interrupt_o <= 1'b1; // RULE_14 RULE_16
         end
         if (res == '0 && rtype_q == `TYPE_ACK) begin
            if (is_data_q) begin
               run_pend_q <= 1'b1;
            end else if (run_pend_q) begin
               run_end_o <= 1'b1; // RULE_15
               run_pend_q <= 1'b0;
            end
         end
      end else begin
         if (result_read_i) begin
            result_valid_o <= 1'b0;
            comm_result_interrupt_o <= 1'b0;
         end
         if (run_end_clear_i) run_end_o <= 1'b0;
      end
   end

   // two bytes shown after every reset
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         boot_data_o <= `BOOT_BYTE0; // RULE_12
         boot_valid_o <= 1'b1;
         boot_second_q <= 1'b0;
      end else if (boot_read_i && boot_valid_o) begin
         boot_data_o <= `BOOT_BYTE1;
         boot_second_q <= 1'b1;
         boot_valid_o <= !boot_second_q;
      end
   end
endmodule : link_controller
`default_nettype wire

//--- core/link_slave.sv
/*
 slave end of the serial link: answers frames addressed to it and
 paces a run of operation pulses; assumes field_serdes is compiled
 first and the address straps are static
*/
`timescale 1ns/1ps
`default_nettype none
`include "slave_link_cfg.svh"

module link_slave #(
   parameter int unsigned GAP = `GAP_CYCLES
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   serial_link_if.slave link,
   input wire slave_link_pkg::slave_addr_t my_address_i,
   output logic pulse_o,
   output logic running_o
);
   import slave_link_pkg::*;
   slave_state_t st_q;
   slave_addr_t adr_s1, adr_s2, raddr_q;
   field_type_t rtype_q, rep_type_q;
   logic [1:0] nf_q;
   logic [7:0] rsum_q, last_q, d0_q, cnt_q, rep_data_q, tsum_q;
   logic first_ctl_q, bad_q, rep_has_data_q, load;
   logic [15:0] gap_q;
   logic [9:0] div_q;
   logic tx_rdy, tx_go, rx_v, rx_fe;
   logic [8:0] tx_f, rx_f;

   field_serdes u_serdes (
      .clk_i(clk_i), .resetn_i(resetn_i),
      .tx_valid_i(tx_go), .tx_field_i(tx_f), .tx_ready_o(tx_rdy),
      .txd_o(link.slv_txd), .rxd_i(link.ctl_txd),
      .rx_valid_o(rx_v), .rx_field_o(rx_f), .rx_frame_err_o(rx_fe));

   // reply field per state
   always_comb begin
      tx_go = tx_rdy && (st_q == S_CTL || st_q == S_DATA || st_q == S_SUM);
      tx_f = {1'b0, tsum_q};
      if (st_q == S_CTL) tx_f = {1'b1, ctl_byte(rep_type_q, adr_s2)};
      if (st_q == S_DATA) tx_f = {1'b0, rep_data_q}; // RULE_09
   end
   assign load = st_q == S_EVAL && rep_type_q == `TYPE_ACK &&
      nf_q == 2'd3;

   // address strap synchroniser
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         adr_s1 <= '0;
         adr_s2 <= '0;
      end else begin
         adr_s1 <= my_address_i;
         adr_s2 <= adr_s1;
      end
   end

   // incoming frame collection, ended by an idle gap
   always_ff @(posedge clk_i) begin
      if (!resetn_i || st_q == S_EVAL) begin
         nf_q <= '0;
         rsum_q <= '0;
         bad_q <= 1'b0;
         gap_q <= '0;
         first_ctl_q <= 1'b0;
         last_q <= '0;
         d0_q <= '0;
         raddr_q <= '0;
         rtype_q <= '0;
      end else if (rx_v) begin
         gap_q <= '0;
         if (nf_q != 2'd3) nf_q <= nf_q + 1'b1;
         rsum_q <= sum_add(rsum_q, rx_f[7:0]);
         last_q <= rx_f[7:0];
         bad_q <= bad_q | rx_fe | (nf_q != '0 && rx_f[`CTL_BIT]);
         if (nf_q == '0) begin
            first_ctl_q <= rx_f[`CTL_BIT]; // RULE_06
            rtype_q <= rx_f[5:4];
            raddr_q <= rx_f[`ADDR_W-1:0];
         end
         if (nf_q == 2'd1) d0_q <= rx_f[7:0];
      end else if (nf_q != '0) begin
         gap_q <= gap_q + 1'b1;
      end
   end

   // answer sequencing
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         st_q <= S_RX;
         rep_type_q <= `TYPE_ACK;
         rep_data_q <= '0;
         rep_has_data_q <= 1'b0;
         tsum_q <= '0;
      end else begin
         case (st_q)
            S_RX: if (nf_q != '0 && !rx_v && gap_q == 16'(GAP - 1)) begin
               st_q <= S_EVAL;
               rep_has_data_q <= 1'b0;
               rep_data_q <= cnt_q;
               if (bad_q || rtype_q[1] || (rsum_q - last_q) != last_q) begin
                  rep_type_q <= `TYPE_ERR; // RULE_18
               end else if (rtype_q == `TYPE_BUSY) begin
                  rep_type_q <= running_o ? `TYPE_BUSY : `TYPE_ACK;
               end else if (nf_q == 2'd2) begin
                  rep_type_q <= `TYPE_DATA; // RULE_08
                  rep_has_data_q <= 1'b1;
               end else begin
                  rep_type_q <= `TYPE_ACK;
               end
            end
            S_EVAL: begin
               // answer only a whole frame sent to this address
               if (first_ctl_q && nf_q >= 2'd2 && raddr_q == adr_s2) begin
                  st_q <= S_CTL; // RULE_10 RULE_11
               end else begin
                  st_q <= S_RX;
               end
            end
            S_CTL: if (tx_go) begin
               tsum_q <= tx_f[7:0];
               st_q <= rep_has_data_q ? S_DATA : S_SUM; // RULE_05
            end
            S_DATA: if (tx_go) begin
               tsum_q <= sum_add(tsum_q, rep_data_q);
               st_q <= S_SUM;
            end
            default: if (tx_go) st_q <= S_RX;
         endcase
      end
   end

   // operation pulse run, length from the first data byte
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cnt_q <= '0;
         div_q <= '0;
         pulse_o <= 1'b0;
         running_o <= 1'b0;
      end else begin
         pulse_o <= 1'b0;
         running_o <= cnt_q != '0;
         if (load) begin
            cnt_q <= d0_q; // RULE_15
            div_q <= '0;
         end else if (cnt_q != '0) begin
            div_q <= div_q + 1'b1;
            if (div_q == 10'(`PULSE_DIV_CYCLES - 1)) begin
               div_q <= '0;
               pulse_o <= 1'b1;
               cnt_q <= cnt_q - 1'b1;
            end
         end
      end
   end
endmodule : link_slave
`default_nettype wire

//--- tb/slave_link_asserts.sv
/*
 checker on the two serial lines between both link ends;
 assumes one clock and a synchronous active-low reset
*/
`timescale 1ns/1ps
`default_nettype none
module slave_link_asserts #(
   parameter int unsigned GAP = 10000
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ctl_txd,
   input wire logic slv_txd
);
   localparam int unsigned MIN_IDLE = GAP - 800;
   logic [15:0] clo_q, slo_q, chi_q, shi_q;
   logic seen_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   function automatic logic [15:0] run(input logic [15:0] c, input logic s);
      run = !s ? 16'h0000 : (c == 16'hffff) ? c : c + 16'h0001;
   endfunction : run
   // low and high run lengths; high runs start saturated
   always_ff @(posedge clk_i) begin
      clo_q <= resetn_i ? run(clo_q, !ctl_txd) : 16'h0000;
      slo_q <= resetn_i ? run(slo_q, !slv_txd) : 16'h0000;
      chi_q <= resetn_i ? run(chi_q, ctl_txd) : 16'hffff;
      shi_q <= resetn_i ? run(shi_q, slv_txd) : 16'hffff;
   end
   // set once the controller has sent anything
   always_ff @(posedge clk_i) begin
      seen_q <= resetn_i && (seen_q || !ctl_txd);
   end
   reset_idle_a: assert property ($rose(resetn_i) |-> ctl_txd && slv_txd)
      else $error("line not idle after reset");
   ctl_bits_a: assert property ($rose(ctl_txd) |-> clo_q % 800 == 0 && clo_q <= 8000)
      else $error("controller low run not whole bits");
   slv_bits_a: assert property ($rose(slv_txd) |-> slo_q % 800 == 0 && slo_q <= 8000)
      else $error("slave low run not whole bits");
   ctl_stop_a: assert property ($fell(ctl_txd) |-> chi_q >= 800)
      else $error("controller stop bit short");
   slv_stop_a: assert property ($fell(slv_txd) |-> shi_q >= 800)
      else $error("slave stop bit short");
   reply_gap_a: assert property ($fell(slv_txd) |-> chi_q >= MIN_IDLE)
      else $error("slave spoke before frame end");
   reply_quiet_a: assert property (!slv_txd |-> ctl_txd)
      else $error("both ends sending at once");
   slave_first_a: assert property (!seen_q |-> slv_txd)
      else $error("slave spoke unasked");
   cover property ($fell(slv_txd));
   cover property (seen_q && $fell(ctl_txd) && chi_q < 900);
   cover property ($rose(slv_txd) && slo_q == 16'h0320);
endmodule : slave_link_asserts
`default_nettype wire

//--- tb/slave_serial_link_framer_bench.sv
/*
 bench for both link ends and the fifo;
 assumes the core files are compiled first
*/
`timescale 1ns/1ps
`default_nettype none
module slave_serial_link_framer_bench;
   logic clk_i = 0, resetn_i = 0, cv = 0, cdat = 0, dv = 0, sel = 0;
   logic rres = 0, rboot = 0, rdr = 0, rec = 0;
   logic [7:0] db = 8'h00, res, boot, rxd;
   logic [3:0] ca = 4'h0, me = 4'h0, ra;
   logic crdy, drdy, rv, irq, bv, pls, rxv, rend, run;
   int seed = 32'hd1a5, miscompares = 0, comparisons = 0, cyc = 0, np = 0;
   logic [12:0] res_q[$];
   logic [7:0] boot_q[$];
   serial_link_if lnk();
   link_controller #(.REPLY_TIMEOUT(18500), .GAP(9000)) i_link_controller (
      .clk_i, .resetn_i, .link(lnk.ctrl), .cmd_valid_i(cv), .cmd_addr_i(ca),
      .cmd_is_data_i(cdat), .cmd_ready_o(crdy), .data_valid_i(dv),
      .data_i(db), .data_last_i(dv), .data_ready_o(drdy),
      .result_report_select_pin_i(sel), .rx_data_o(rxd),
      .rx_data_valid_o(rxv), .rx_data_read_i(rdr), .result_addr_o(ra),
      .result_o(res), .result_valid_o(rv), .result_read_i(rres),
      .comm_result_interrupt_o(irq), .run_end_o(rend),
      .run_end_clear_i(rec), .boot_data_o(boot), .boot_valid_o(bv),
      .boot_read_i(rboot));
   link_slave #(.GAP(9000)) i_link_slave (.clk_i, .resetn_i,
      .link(lnk.slave), .my_address_i(me), .pulse_o(pls), .running_o(run));
   slave_link_asserts #(.GAP(9000)) i_slave_link_asserts (.clk_i,
      .resetn_i, .ctl_txd(lnk.ctl_txd), .slv_txd(lnk.slv_txd));
   initial forever #5 clk_i = ~clk_i;
   task automatic check(input logic [12:0] seen, input logic [12:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test
   // take results and boot bytes off their queues as they show
   always @(negedge clk_i) begin
      rres <= 1'b0;
      rboot <= 1'b0;
      rdr <= rxv;
      rec <= rend;
      if (resetn_i && rv === 1'b1 && !rres) begin
         check({ra, res, irq}, res_q.pop_front());
         rres <= 1'b1;
      end
      if (resetn_i && bv === 1'b1 && !rboot) begin
         check({5'h00, boot}, {5'h00, boot_q.pop_front()});
         rboot <= 1'b1;
      end
   end
   // count pulses, cut a hang short at cycle 100000
   always @(posedge clk_i) begin
      cyc++;
      if (pls === 1'b1) np++;
      if (cyc == 100000) begin
         miscompares++;
         finish_test();
      end
   end
   initial begin
      boot_q = '{8'hf0, 8'h80};
      me = 4'($random(seed));
      sel = 1'($random(seed));
      db = 8'($random(seed) & 7) + 8'h01;
      repeat (20) @(negedge clk_i);
      resetn_i = 1'b1;
      check({10'h000, crdy, drdy, bv}, 13'h0007);
      // one data byte sets the pulse count of a data frame
      dv = 1'b1;
      do @(posedge clk_i); while (drdy !== 1'b1);
      @(negedge clk_i);
      dv = 1'b0;
      check({12'h000, drdy}, 13'h0001);
      for (int k = 0; k < 2; k++) begin
         ca = k ? me ^ 4'h5 : me;
         cdat = !k;
         res_q.push_back(k ? {ca, 8'h80, 1'b1} : {ca, 8'h00, sel});
         cv = 1'b1;
         do @(posedge clk_i); while (crdy !== 1'b1);
         @(negedge clk_i);
         cv = 1'b0;
         wait (res_q.size() == 0);
         if (!k) check({5'h00, np[7:0]}, {5'h00, db});
      end
      @(negedge clk_i);
      check({rxd, rend, rxv, run, drdy, crdy}, 13'h0003);
      finish_test();
   end
endmodule : slave_serial_link_framer_bench
`default_nettype wire
